// >>> rtl/sccr_top.v
`timescale 1ns/100ps
`include "sccr_regs.vh"

// Operation
// - DMA priority bit high gives DMA top SRAM priority, low gives least-recently-serviced.
// - CPU priority bit high gives the CPU top SRAM priority during interrupt service.
// - Capture timebase bit low selects timers 2/3 for all capture modules, high the alt pair.
// - Compare timebase bit low selects timers 2/3 for all compare modules, high the alt pair.
// - Pin-select lock high refuses writes to the pin-select registers.
// - Module-disable lock high refuses writes to the module-disable registers.
// - Permission-group lock high refuses writes to the permission-group registers.
// - USB sleep bit high stops the USB PHY clock while sleep is active.
// - Protected fields change only after the unlock sequence, else writes leave them alone.
// - Unimplemented bits ignore writes and read as zero.
module sccr_top (
  // APB clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Unlock sequencer and system state
  input wire sys_unlocked,
  input wire sleep_active,
  // Arbitration and timebase controls
  output reg dma_sram_priority,
  output reg cpu_isr_sram_priority,
  output reg cpu_isr_high_pri,
  output reg capture_timebase_alt_select,
  output reg compare_timebase_alt_select,
  // USB PHY clock control
  output reg usb_phy_sleep_gate,
  output reg usb_phy_clk_en,
  // CPU interrupt state, protected register write requests and grants
  input wire cpu_in_isr,
  input wire pin_select_wr_req,
  input wire module_disable_wr_req,
  input wire permission_group_wr_req,
  output wire pin_select_wr_en,
  output wire module_disable_wr_en,
  output wire permission_group_wr_en
);

  // ==========================================================
  // Register storage
  // Only the config word and one sticky flag are real state; the
  // status bits for unlock and sleep are live views of their inputs.
  reg [31:0] cfg;
  reg refused_sticky;
  wire pin_select_lock;
  wire module_disable_lock;
  wire permission_group_lock;
  wire ref_pin;
  wire ref_mod;
  wire ref_perm;
  wire any_refused;

  // Lock bits feed the write gates
  assign pin_select_lock = cfg[`SCCR_BIT_PIN_LOCK];
  assign module_disable_lock = cfg[`SCCR_BIT_MOD_LOCK];
  assign permission_group_lock = cfg[`SCCR_BIT_PERM_LOCK];

  // Any refusal from the three gates sets the sticky flag
  assign any_refused = ref_pin | ref_mod | ref_perm;

  // ==========================================================
  // APB decode
  // Writes act at the end of the access phase; pready is always
  // high there, so no wait-state qualifier is needed.
  wire access_phase;
  wire wr_cfg;
  wire wr_status;
  wire addr_ok;

  assign access_phase = psel & penable;
  assign addr_ok = (paddr == `SCCR_OFF_CONFIG) | (paddr == `SCCR_OFF_STATUS);
  assign wr_cfg = access_phase & pwrite & (paddr == `SCCR_OFF_CONFIG);
  assign wr_status = access_phase & pwrite & (paddr == `SCCR_OFF_STATUS);

  // Zero wait states: pready is high in every access phase.
  // It is low only in reset, so a master that starts at the
  // first edge after release still sees it high in access.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= 1'b1;
    end
  end

  // Error on unmapped offsets. Decoded in the setup cycle and
  // registered, so it stands for exactly the access phase and
  // comes from a flop like every other output.
  reg next_pslverr;

  always @* begin
    next_pslverr = 1'b0;
    if (psel && !penable && !addr_ok) begin
      next_pslverr = 1'b1;
    end
  end

  // Error flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= next_pslverr;
    end
  end

  // ==========================================================
  // Configuration register: all fields protected, so every
  // write is ignored unless the sequencer reports unlocked.
  // A locked write is dropped silently; software must read back.
  reg [31:0] next_cfg;

  always @* begin
    next_cfg = cfg;
    if (wr_cfg && sys_unlocked) begin
      next_cfg = pwdata & `SCCR_CFG_MASK;
    end
  end

  // Config flop; cleared by reset or by an unlocked write of zero
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= `SCCR_CFG_RESET;
    end else begin
      cfg <= next_cfg;
    end
  end

  // ==========================================================
  // Sticky refusal flag, cleared by writing one to its status bit.
  // A refusal in the same cycle as the clear wins, so software
  // never loses a refused write between reading and clearing.
  reg next_refused;

  always @* begin
    next_refused = refused_sticky;
    if (wr_status && pwdata[`SCCR_ST_REFUSED]) begin
      next_refused = 1'b0;
    end
    if (any_refused) begin
      next_refused = 1'b1;
    end
  end

  // Status flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refused_sticky <= 1'b0;
    end else begin
      refused_sticky <= next_refused;
    end
  end

  // ==========================================================
  // Read data, captured in the setup cycle so it is ready in access.
  // Holding it until the next read setup costs one 32-bit flop
  // but keeps prdata free of any path from paddr.
  reg [31:0] next_prdata;

  always @* begin
    next_prdata = prdata;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        `SCCR_OFF_CONFIG: begin
          next_prdata = cfg & `SCCR_CFG_MASK;
        end
        `SCCR_OFF_STATUS: begin
          next_prdata = {29'h0000000, refused_sticky, sleep_active, sys_unlocked};
        end
        default: begin
          next_prdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // Read data flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= next_prdata;
    end
  end

  // ==========================================================
  // Control outputs driven from flops.
  // Each follows the config word one cycle late; the arbiter and
  // timer muxes sit far away, so the extra flop eases timing.
  // The USB clock enable resets high so the PHY clock runs until
  // software asks for it to stop in sleep.

  // DMA priority to SRAM
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_sram_priority <= 1'b0;
    end else begin
      dma_sram_priority <= cfg[`SCCR_BIT_DMA_PRI];
    end
  end

  // CPU priority setting as stored
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_isr_sram_priority <= 1'b0;
    end else begin
      cpu_isr_sram_priority <= cfg[`SCCR_BIT_CPU_PRI];
    end
  end

  // High priority only while an interrupt is being serviced
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_isr_high_pri <= 1'b0;
    end else begin
      cpu_isr_high_pri <= cfg[`SCCR_BIT_CPU_PRI] & cpu_in_isr;
    end
  end

  // Capture timebase pair select
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_timebase_alt_select <= 1'b0;
    end else begin
      capture_timebase_alt_select <= cfg[`SCCR_BIT_CAP_ALT];
    end
  end

  // Compare timebase pair select
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_timebase_alt_select <= 1'b0;
    end else begin
      compare_timebase_alt_select <= cfg[`SCCR_BIT_CMP_ALT];
    end
  end

  // USB sleep gate setting as stored
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      usb_phy_sleep_gate <= 1'b0;
    end else begin
      usb_phy_sleep_gate <= cfg[`SCCR_BIT_USB_SLEEP];
    end
  end

  // USB PHY clock enable, low only in sleep with the gate set
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      usb_phy_clk_en <= 1'b1;
    end else begin
      usb_phy_clk_en <= ~(cfg[`SCCR_BIT_USB_SLEEP] & sleep_active);
    end
  end

  // ==========================================================
  // Write gates for the three locked register groups, one per
  // group: bit 0 pin select, bit 1 module disable, bit 2
  // permission group. Each gate registers its grant, so a lock
  // set in one cycle already refuses a request in the next.
  wire [2:0] grp_req;
  wire [2:0] grp_lock;
  wire [2:0] grp_grant;
  wire [2:0] grp_refused;

  assign grp_req = {permission_group_wr_req, module_disable_wr_req, pin_select_wr_req};
  assign grp_lock[0] = pin_select_lock;
  assign grp_lock[1] = module_disable_lock;
  assign grp_lock[2] = permission_group_lock;

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : gen_gate
      sccr_write_gate u_gate (
        .pclk(pclk),
        .presetn(presetn),
        .wr_req(grp_req[g]),
        .lock(grp_lock[g]),
        .wr_grant(grp_grant[g]),
        .wr_refused(grp_refused[g])
      );
    end
  endgenerate

  // Grants out, refusals into the sticky flag
  assign pin_select_wr_en = grp_grant[0];
  assign module_disable_wr_en = grp_grant[1];
  assign permission_group_wr_en = grp_grant[2];
  assign ref_pin = grp_refused[0];
  assign ref_mod = grp_refused[1];
  assign ref_perm = grp_refused[2];

endmodule

// >>> inc/sccr_regs.vh
`ifndef SCCR_REGS_VH
`define SCCR_REGS_VH

// ==========================================================
// Register offsets (byte addresses)
`define SCCR_OFF_CONFIG 12'h000
`define SCCR_OFF_STATUS 12'h004

// ==========================================================
// Configuration control field positions
`define SCCR_BIT_DMA_PRI 25
`define SCCR_BIT_CPU_PRI 24
`define SCCR_BIT_CAP_ALT 17
`define SCCR_BIT_CMP_ALT 16
`define SCCR_BIT_PIN_LOCK 13
`define SCCR_BIT_MOD_LOCK 12
`define SCCR_BIT_PERM_LOCK 11
`define SCCR_BIT_USB_SLEEP 8

// Writable field mask and reset value
`define SCCR_CFG_MASK 32'h0303_3900
`define SCCR_CFG_RESET 32'h0000_0000

// Status register field positions
`define SCCR_ST_UNLOCKED 0
`define SCCR_ST_SLEEP 1
`define SCCR_ST_REFUSED 2

`endif

// >>> rtl/sccr_write_gate.v
`timescale 1ns/100ps
`include "sccr_regs.vh"

// Write gate for one group of lock-protected registers
module sccr_write_gate (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Request and lock
  input wire wr_req,
  input wire lock,
  // Result
  output reg wr_grant,
  output reg wr_refused
);

  // ==========================================================
  // Grant or refuse, registered so outputs come from flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_grant <= 1'b0;
      wr_refused <= 1'b0;
    end else begin
      wr_grant <= wr_req & ~lock;
      wr_refused <= wr_req & lock;
    end
  end

endmodule

// >>> verif/sccr_props.sv
`timescale 1ns/100ps
// ====
// Port checks for the config register
module sccr_props (
  // Bus
  input wire pclk, presetn, psel, penable, pwrite, pready,
  input wire [11:0] paddr,
  input wire [31:0] pwdata, prdata,
  // System side
  input wire sys_unlocked, sleep_active, cpu_in_isr,
  input wire dma_sram_priority, cpu_isr_high_pri, usb_phy_clk_en,
  input wire capture_timebase_alt_select, compare_timebase_alt_select,
  input wire pin_select_wr_req, module_disable_wr_req, permission_group_wr_req,
  input wire pin_select_wr_en, module_disable_wr_en, permission_group_wr_en
);
  logic [31:0] sh;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Shadow word, kept apart so a stuck config register shows
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sh <= 32'h0;
    else if (psel && penable && pready && pwrite && paddr == 12'h000 && sys_unlocked)
      sh <= pwdata & 32'h0303_3900;
  end
  // ====
  // Assertions
  a_dma_pri: assert property (dma_sram_priority == $past(sh[25])) else $error("dma");
  a_isr_pri: assert property (cpu_isr_high_pri == $past(sh[24] && cpu_in_isr))
    else $error("isr");
  a_cap_sel: assert property (capture_timebase_alt_select == $past(sh[17]))
    else $error("cap");
  a_cmp_sel: assert property (compare_timebase_alt_select == $past(sh[16]))
    else $error("cmp");
  a_usb_clk: assert property (usb_phy_clk_en == !$past(sh[8] && sleep_active))
    else $error("usb");
  a_pin_gate: assert property (pin_select_wr_req |=> pin_select_wr_en == !$past(sh[13]))
    else $error("pin");
  a_mod_gate: assert property (module_disable_wr_req |=> module_disable_wr_en != $past(sh[12]))
    else $error("mod");
  a_perm_gate: assert property (permission_group_wr_req |=>
    permission_group_wr_en == !$past(sh[11])) else $error("perm");
  a_cfg_read: assert property (psel && penable && !pwrite && paddr == 12'h000 |->
    prdata == sh) else $error("read");
  c_locked: cover property (psel && penable && pwrite && !sys_unlocked);
  c_pin: cover property (pin_select_wr_req && sh[13]);
  c_sleep: cover property (sh[8] && sleep_active);
endmodule

// >>> verif/sccr_top_tb.sv
`timescale 1ns/100ps
module sccr_top_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd, d, model = 0;
  logic sys_unlocked = 0, sleep_active = 0, cpu_in_isr = 0, ref_m = 0;
  logic pin_select_wr_req = 0, module_disable_wr_req = 0, permission_group_wr_req = 0;
  wire [31:0] prdata;
  wire pready, pslverr, dma_sram_priority, cpu_isr_sram_priority, cpu_isr_high_pri;
  wire capture_timebase_alt_select, compare_timebase_alt_select, usb_phy_sleep_gate;
  wire usb_phy_clk_en, pin_select_wr_en, module_disable_wr_en, permission_group_wr_en;
  int fail_count = 0, num_checks = 0;
  sccr_top dut (.*);
  // Clock at 20 MHz
  initial forever #25 pclk = ~pclk;
  // ====
  // Helpers
  task chk(input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task tally_and_finish;
    if (fail_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Locked writes leave the word alone
  function automatic logic [31:0] nxt(input logic [31:0] m, w, input logic u);
    return u ? (w & 32'h0303_3900) : m;
  endfunction
  // One APB transfer; bounded wait on pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int i;
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 16);
    if (pready !== 1'b1) begin
      fail_count++;
      tally_and_finish;
    end
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  // ====
  // Main sequence
  initial begin
    void'($urandom(32'h786B023E));
    repeat (16) @(posedge pclk);
    presetn <= 1;
    apb(0, 12'h000, 0); chk(rd, 0);
    chk(err, 0);
    apb(0, 12'h008, 0); chk(err, 1);
    for (int n = 0; n < 40; n++) begin
      d = n == 0 ? 32'hFFFF_FFFF : $urandom;
      sys_unlocked <= n == 0 ? 1'b1 : n == 1 ? 1'b0 : 1'($urandom);
      sleep_active <= 1'($urandom); cpu_in_isr <= 1'($urandom);
      apb(1, 12'h000, d);
      model = nxt(model, d, sys_unlocked);
      repeat (2) @(posedge pclk);
      chk({dma_sram_priority, cpu_isr_sram_priority, capture_timebase_alt_select,
        compare_timebase_alt_select, usb_phy_sleep_gate}, {model[25:24], model[17:16],
        model[8]});
      chk({cpu_isr_high_pri, usb_phy_clk_en}, {model[24] & cpu_in_isr,
        !(model[8] & sleep_active)});
      {pin_select_wr_req, module_disable_wr_req, permission_group_wr_req} <= 3'h7;
      @(posedge pclk);
      {pin_select_wr_req, module_disable_wr_req, permission_group_wr_req} <= 3'h0;
      @(posedge pclk);
      chk({pin_select_wr_en, module_disable_wr_en, permission_group_wr_en},
        ~model[13:11] & 3'h7);
      ref_m = ref_m | (|model[13:11]);
      apb(0, 12'h000, 0); chk(rd, model);
    end
    apb(1, 12'h008, 32'hFFFF_FFFF); chk(err, 1);
    apb(0, 12'h000, 0); chk(rd, model);
    apb(0, 12'h004, 0); chk(rd, {29'h0, ref_m, sleep_active, sys_unlocked});
    apb(1, 12'h004, 32'h0000_0004);
    apb(0, 12'h004, 0); chk(rd, {29'h0, 1'b0, sleep_active, sys_unlocked});
    tally_and_finish;
  end
endmodule
bind sccr_top sccr_props u_props (.*);
